// ### hw/wwdt_regs.vh
// register offsets, field positions, reset values and counts of the supervision timer
// assumes an 8-bit AXI4-Lite byte address with one 32-bit word per register
`ifndef WWDT_REGS_VH
`define WWDT_REGS_VH

`define WWDT_OFS_CTRL 8'h00
`define WWDT_OFS_RELOAD 8'h04
`define WWDT_OFS_WINDOW 8'h08
`define WWDT_OFS_SERVICE 8'h0C
`define WWDT_OFS_COUNT 8'h10
`define WWDT_OFS_STATUS 8'h14
`define WWDT_OFS_MASK 8'h18
`define WWDT_OFS_STATE 8'h1C

`define WWDT_CTRL_ENABLE 0
`define WWDT_CTRL_WIN_EN 1
`define WWDT_CTRL_RATE_SEL 2

`define WWDT_ST_OVERFLOW 0
`define WWDT_ST_WINDOW 1
`define WWDT_ST_RESET 2

`define WWDT_RST_CTRL 3'h0
`define WWDT_RST_RELOAD 8'h00
`define WWDT_RST_WINDOW 8'h00
`define WWDT_RST_MASK 3'h0

`define WWDT_DIV_SLOW 8'h80
`define WWDT_DIV_FAST 8'h02
`define WWDT_PREWARN_TICKS 8'h30

`define WWDT_RESP_OKAY 2'h0
`define WWDT_RESP_SLVERR 2'h2

`endif

// ### hw/wwdt_prescale.v
// tick generator: one-cycle tick every fast or slow divide of the peripheral clock
// assumes clear and run are synchronous to core_clk
`timescale 1ns/1ps
`include "wwdt_regs.vh"

module wwdt_prescale #(
    parameter [7:0] DIV_FAST = `WWDT_DIV_FAST,
    parameter [7:0] DIV_SLOW = `WWDT_DIV_SLOW
) (
    input wire core_clk,
    input wire srst,
    input wire run,
    input wire rate_sel,
    input wire clear,
    output reg tick
);
    reg [7:0] div_cnt;
    wire [7:0] limit = rate_sel ? (DIV_SLOW - 8'h01) : (DIV_FAST - 8'h01);

    always @(posedge core_clk) begin
        if (srst || clear) begin
            div_cnt <= 8'h00;
            tick <= 1'b0;
        end else if (run) begin
            // frozen while not running, so debug halts keep phase
            if (div_cnt >= limit) begin
                div_cnt <= 8'h00;
                tick <= 1'b1;
            end else begin
                div_cnt <= div_cnt + 8'h01;
                tick <= 1'b0;
            end
        end else begin
            tick <= 1'b0;
        end
    end
endmodule

// ### hw/wwdt_top.v
// windowed supervision timer with AXI4-Lite register slave and sticky interrupt
// assumes a single core_clk domain, srst synchronous, debug_mode synchronous level
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "wwdt_regs.vh"

module wwdt_top #(
    parameter [7:0] PREWARN_TICKS = `WWDT_PREWARN_TICKS
) (
    input wire core_clk,
    input wire srst,
    input wire debug_mode,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg timeout_alarm,
    output reg system_reset_request,
    output reg irq
);
    localparam [2:0] ST_COUNT = 3'b001;
    localparam [2:0] ST_PREWARN = 3'b010;
    localparam [2:0] ST_RESET = 3'b100;

    function is_mapped;
        input [7:0] addr;
        begin
            is_mapped = (addr[1:0] == 2'b00) && (addr <= `WWDT_OFS_STATE);
        end
    endfunction

    function wr_hit;
        input fire;
        input [7:0] addr;
        input [7:0] ofs;
        input strb0;
        begin
            wr_hit = fire && (addr == ofs) && strb0;
        end
    endfunction

    // bus holding registers
    reg aw_full;
    reg w_full;
    reg [7:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    // software state
    reg [2:0] ctrl;
    reg [7:0] reload_high_byte;
    reg [7:0] window_bound_byte;
    reg [2:0] status;
    reg [2:0] mask;

    // timer state
    reg [7:0] cnt_lo;
    reg [7:0] cnt_hi;
    reg [7:0] pw_cnt;
    reg [2:0] state;

    reg next_aw_full;
    reg next_w_full;
    reg [2:0] next_status;
    reg [2:0] status_set;

    wire wr_fire = aw_full && w_full && !s_axi_bvalid;
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire wdt_enable = ctrl[`WWDT_CTRL_ENABLE];
    wire win_enable = ctrl[`WWDT_CTRL_WIN_EN];
    wire input_rate_select = ctrl[`WWDT_CTRL_RATE_SEL];
    wire [15:0] count = {cnt_hi, cnt_lo};
    wire [15:0] window_top = {window_bound_byte, 8'h00};

    wire service = wr_hit(wr_fire, aw_addr_q, `WWDT_OFS_SERVICE, w_strb_q[0]);
    wire service_ok = service && (state == ST_COUNT);
    wire window_hit = win_enable && (count < window_top);
    wire tick;
    // prewarning keeps running even if software disables the timer
    wire run = ((wdt_enable && (state == ST_COUNT)) || (state == ST_PREWARN))
        && !debug_mode;

    wwdt_prescale u_prescale (
        .core_clk(core_clk),
        .srst(srst),
        .run(run),
        .rate_sel(input_rate_select),
        .clear(service_ok),
        .tick(tick)
    );

    // write channel: address and data taken in either order
    always @* begin
        next_aw_full = aw_full;
        next_w_full = w_full;
        if (s_axi_awvalid && s_axi_awready)
            next_aw_full = 1'b1;
        if (s_axi_wvalid && s_axi_wready)
            next_w_full = 1'b1;
        if (wr_fire) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
        end
    end

    always @(posedge core_clk) begin
        if (srst) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `WWDT_RESP_OKAY;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            s_axi_awready <= !next_aw_full;
            s_axi_wready <= !next_w_full;
            if (s_axi_awvalid && s_axi_awready)
                aw_addr_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(aw_addr_q) ? `WWDT_RESP_OKAY : `WWDT_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel: one outstanding read, answer one cycle after the address
    always @(posedge core_clk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `WWDT_RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= is_mapped(s_axi_araddr) ? `WWDT_RESP_OKAY : `WWDT_RESP_SLVERR;
            case (s_axi_araddr)
                `WWDT_OFS_CTRL: s_axi_rdata <= {29'h00000000, ctrl};
                `WWDT_OFS_RELOAD: s_axi_rdata <= {24'h000000, reload_high_byte};
                `WWDT_OFS_WINDOW: s_axi_rdata <= {24'h000000, window_bound_byte};
                `WWDT_OFS_COUNT: s_axi_rdata <= {16'h0000, count};
                `WWDT_OFS_STATUS: s_axi_rdata <= {29'h00000000, status};
                `WWDT_OFS_MASK: s_axi_rdata <= {29'h00000000, mask};
                `WWDT_OFS_STATE: s_axi_rdata <= {16'h0000, pw_cnt, 5'h00, state};
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // software registers; all fields live in byte lane 0
    always @(posedge core_clk) begin
        if (srst) begin
            ctrl <= `WWDT_RST_CTRL;
            reload_high_byte <= `WWDT_RST_RELOAD;
            window_bound_byte <= `WWDT_RST_WINDOW;
            mask <= `WWDT_RST_MASK;
        end else begin
            if (wr_hit(wr_fire, aw_addr_q, `WWDT_OFS_CTRL, w_strb_q[0]))
                ctrl <= w_data_q[2:0];
            if (wr_hit(wr_fire, aw_addr_q, `WWDT_OFS_RELOAD, w_strb_q[0]))
                reload_high_byte <= w_data_q[7:0];
            // a bound below the reload value is accepted; software owns that choice
            if (wr_hit(wr_fire, aw_addr_q, `WWDT_OFS_WINDOW, w_strb_q[0]))
                window_bound_byte <= w_data_q[7:0];
            if (wr_hit(wr_fire, aw_addr_q, `WWDT_OFS_MASK, w_strb_q[0]))
                mask <= w_data_q[2:0];
        end
    end

    // timer and prewarning sequence
    always @(posedge core_clk) begin
        if (srst) begin
            cnt_lo <= 8'h00;
            cnt_hi <= 8'h00;
            pw_cnt <= 8'h00;
            state <= ST_COUNT;
            timeout_alarm <= 1'b0;
            system_reset_request <= 1'b0;
        end else begin
            case (state)
                ST_COUNT: begin
                    if (service && window_hit) begin
                        state <= ST_PREWARN;
                        pw_cnt <= 8'h00;
                    end else if (service) begin
                        cnt_hi <= reload_high_byte;
                        cnt_lo <= 8'h00;
                    end else if (tick) begin
                        if (count == 16'hFFFF) begin
                            timeout_alarm <= 1'b1;
                            state <= ST_PREWARN;
                            pw_cnt <= 8'h00;
                        end
                        // low byte carries into high byte
                        cnt_lo <= cnt_lo + 8'h01;
                        if (cnt_lo == 8'hFF)
                            cnt_hi <= cnt_hi + 8'h01;
                    end
                end
                ST_PREWARN: begin
                    // services are ignored once prewarning has begun
                    if (tick) begin
                        if (pw_cnt == PREWARN_TICKS - 8'h01) begin
                            state <= ST_RESET;
                            system_reset_request <= 1'b1;
                        end else begin
                            pw_cnt <= pw_cnt + 8'h01;
                        end
                    end
                end
                ST_RESET: begin
                    // held until the system applies srst
                    system_reset_request <= 1'b1;
                end
                default: begin
                    state <= ST_COUNT;
                end
            endcase
        end
    end

    // sticky status; a set in the clearing cycle wins
    always @* begin
        status_set = 3'b000;
        status_set[`WWDT_ST_OVERFLOW] = (state == ST_COUNT) && tick && !service
            && (count == 16'hFFFF);
        status_set[`WWDT_ST_WINDOW] = (state == ST_COUNT) && service && window_hit;
        status_set[`WWDT_ST_RESET] = (state == ST_PREWARN) && tick
            && (pw_cnt == PREWARN_TICKS - 8'h01);
        next_status = status;
        if (wr_hit(wr_fire, aw_addr_q, `WWDT_OFS_STATUS, w_strb_q[0]))
            next_status = status & ~w_data_q[2:0];
        next_status = next_status | status_set;
    end

    always @(posedge core_clk) begin
        if (srst) begin
            status <= 3'b000;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            irq <= |(next_status & mask);
        end
    end
endmodule

// ### test/wwdt_checker.sv
// checker: bus handshakes and alarm sequencing of the supervision timer
// assumes it is bound to wwdt_top and sees only its ports
`timescale 1ns/1ps
module wwdt_checker #(
    parameter [7:0] PREWARN_TICKS = 8'h30
) (
    input wire core_clk,
    input wire srst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire timeout_alarm,
    input wire system_reset_request,
    input wire irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    a_alarm_sticky: assert property (timeout_alarm |=> timeout_alarm)
        else $error("alarm dropped");
    a_request_sticky: assert property (system_reset_request |=> system_reset_request)
        else $error("reset request dropped");
    // fastest divide is 2, so a budget of three or more ticks cannot end prewarning in six cycles
    a_prewarn_min: assert property ($rose(timeout_alarm) |-> !system_reset_request [*6])
        else $error("prewarning too short");
    a_quiet_release: assert property ($fell(srst) |-> !timeout_alarm && !system_reset_request && !irq)
        else $error("outputs not quiet after reset");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered");
    a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read taken");
    c_alarm: cover property ($rose(timeout_alarm));
    c_request: cover property ($rose(system_reset_request) && !timeout_alarm);
    c_irq: cover property ($fell(irq));
endmodule
bind wwdt_top wwdt_checker #(.PREWARN_TICKS(PREWARN_TICKS)) u_chk (.core_clk(core_clk),
    .srst(srst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .timeout_alarm(timeout_alarm),
    .system_reset_request(system_reset_request), .irq(irq));

// ### test/wwdt_sysrst_model.sv
// system reset logic model: measures prewarning length between alarm and reset request
// assumes one core_clk domain with srst synchronous
`timescale 1ns/1ps
module wwdt_sysrst_model (
    input wire core_clk,
    input wire srst,
    input wire timeout_alarm,
    input wire system_reset_request,
    output reg [15:0] gap
);
    always @(posedge core_clk) begin
        if (srst) begin
            gap <= 16'h0000;
        end else if (timeout_alarm && !system_reset_request) begin
            gap <= gap + 16'h0001;
        end
    end
endmodule

// ### test/test_windowed_watchdog_timer.sv
// testbench: drives the supervision timer over AXI4-Lite, judges alarm, reset and irq
// assumes wwdt_top, the checker and the reset logic model are compiled with it
`timescale 1ns/1ps
`include "wwdt_regs.vh"
module test_windowed_watchdog_timer;
    // short prewarning keeps the run brief
    localparam [7:0] PW = 8'h04;
    reg core_clk = 1'b0;
    reg srst = 1'b1;
    reg debug_mode = 1'b0;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00;
    reg [31:0] wdata = 32'h0, v, w;
    wire awready, wready, bvalid, arready, rvalid, alarm, sysreq, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [15:0] gap;
    integer n_fail = 0, n_compared = 0, n;
    always #20 core_clk = ~core_clk;
    wwdt_top #(.PREWARN_TICKS(PW)) uut (.core_clk(core_clk), .srst(srst), .debug_mode(debug_mode),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .timeout_alarm(alarm), .system_reset_request(sysreq), .irq(irq));
    wwdt_sysrst_model u_rst (.core_clk(core_clk), .srst(srst), .timeout_alarm(alarm),
        .system_reset_request(sysreq), .gap(gap));
    task chk(input string nm, input [31:0] s, input [31:0] e);
        begin
            n_compared = n_compared + 1;
            if (s !== e) begin
                n_fail = n_fail + 1;
                $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("compared %0d failed %0d", n_compared, n_fail);
            if (n_fail == 0 && n_compared > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task hang;
        begin
            n_fail = n_fail + 1;
            tally_and_finish;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        integer i;
        reg dn;
        begin
            @(posedge core_clk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            dn = 1'b0;
            for (i = 0; i < 40 && !dn; i = i + 1) begin
                @(posedge core_clk);
                if (awvalid && awready) awvalid <= 1'b0;
                if (wvalid && wready) wvalid <= 1'b0;
                if (bvalid === 1'b1) begin
                    dn = 1'b1;
                    bready <= 1'b0;
                    chk("bresp", {30'h0, bresp}, {30'h0, er});
                end
            end
            if (!dn) hang;
        end
    endtask
    task rd(input [7:0] a, input [1:0] er, output [31:0] d);
        integer i;
        reg dn;
        begin
            @(posedge core_clk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            dn = 1'b0;
            for (i = 0; i < 40 && !dn; i = i + 1) begin
                @(posedge core_clk);
                if (arvalid && arready) arvalid <= 1'b0;
                if (rvalid === 1'b1) begin
                    dn = 1'b1;
                    rready <= 1'b0;
                    d = rdata;
                    chk("rresp", {30'h0, rresp}, {30'h0, er});
                end
            end
            if (!dn) hang;
        end
    endtask
    task wait_hi(input bit pick, input integer lim);
        begin
            n = 0;
            while ((pick ? sysreq : alarm) !== 1'b1 && n < lim) begin
                @(posedge core_clk);
                n = n + 1;
            end
            if (n >= lim) hang;
        end
    endtask
    task do_reset;
        begin
            @(posedge core_clk);
            srst <= 1'b1;
            repeat (16) @(posedge core_clk);
            srst <= 1'b0;
        end
    endtask
    task t_regs;
        begin
            rd(`WWDT_OFS_CTRL, `WWDT_RESP_OKAY, v);
            chk("ctrl reset", v, 32'h0);
            rd(`WWDT_OFS_MASK, `WWDT_RESP_OKAY, v);
            chk("mask reset", v, 32'h0);
            wr(8'h20, 32'hFF, `WWDT_RESP_SLVERR);
            rd(8'h20, `WWDT_RESP_SLVERR, v);
            chk("unmapped read", v, 32'h0);
            $display("test regs done");
        end
    endtask
    task t_overflow;
        begin
            wr(`WWDT_OFS_RELOAD, 32'hFF, `WWDT_RESP_OKAY);
            wr(`WWDT_OFS_MASK, 32'h7, `WWDT_RESP_OKAY);
            wr(`WWDT_OFS_CTRL, 32'h1, `WWDT_RESP_OKAY);
            wr(`WWDT_OFS_SERVICE, 32'h1, `WWDT_RESP_OKAY);
            wait_hi(1'b0, 700);
            chk("overflow time", n >= 505 && n <= 515, 32'h1);
            chk("irq", irq, 32'h1);
            wait_hi(1'b1, 100);
            chk("prewarn", gap >= 2 * PW - 1 && gap <= 2 * PW + 1, 32'h1);
            rd(`WWDT_OFS_STATUS, `WWDT_RESP_OKAY, v);
            chk("status", v, 32'h5);
            wr(`WWDT_OFS_STATUS, 32'h7, `WWDT_RESP_OKAY);
            repeat (2) @(posedge core_clk);
            chk("irq cleared", irq, 32'h0);
            chk("alarm latched", alarm, 32'h1);
            $display("test overflow done");
        end
    endtask
    task t_window;
        begin
            do_reset;
            wr(`WWDT_OFS_RELOAD, 32'h30, `WWDT_RESP_OKAY);
            wr(`WWDT_OFS_WINDOW, 32'h40, `WWDT_RESP_OKAY);
            wr(`WWDT_OFS_CTRL, 32'h1, `WWDT_RESP_OKAY);
            wr(`WWDT_OFS_SERVICE, 32'h1, `WWDT_RESP_OKAY);
            rd(`WWDT_OFS_COUNT, `WWDT_RESP_OKAY, v);
            chk("reload", v >> 8, 32'h30);
            debug_mode <= 1'b1;
            rd(`WWDT_OFS_COUNT, `WWDT_RESP_OKAY, v);
            repeat (20) @(posedge core_clk);
            rd(`WWDT_OFS_COUNT, `WWDT_RESP_OKAY, w);
            chk("frozen", w, v);
            debug_mode <= 1'b0;
            wr(`WWDT_OFS_CTRL, 32'h3, `WWDT_RESP_OKAY);
            wr(`WWDT_OFS_SERVICE, 32'h1, `WWDT_RESP_OKAY);
            rd(`WWDT_OFS_STATUS, `WWDT_RESP_OKAY, v);
            chk("window status", v, 32'h2);
            wait_hi(1'b1, 100);
            chk("no alarm", alarm, 32'h0);
            $display("test window done");
        end
    endtask
    // slow rate: first tick lands 129 clocks after the service, second at 257
    task t_slow;
        begin
            do_reset;
            wr(`WWDT_OFS_RELOAD, 32'hFF, `WWDT_RESP_OKAY);
            wr(`WWDT_OFS_CTRL, 32'h5, `WWDT_RESP_OKAY);
            wr(`WWDT_OFS_SERVICE, 32'h1, `WWDT_RESP_OKAY);
            rd(`WWDT_OFS_COUNT, `WWDT_RESP_OKAY, v);
            chk("slow start", v, 32'hFF00);
            repeat (190) @(posedge core_clk);
            rd(`WWDT_OFS_COUNT, `WWDT_RESP_OKAY, v);
            chk("slow rate", v, 32'hFF01);
            $display("test slow done");
        end
    endtask
    initial begin
        do_reset;
        t_regs;
        t_overflow;
        t_window;
        t_slow;
        tally_and_finish;
    end
endmodule
